//--- ttc_defs.svh
// register offsets, field positions, reset values and divider counts of the timer block
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

`define TTC_ADDR_W        8
`define TTC_OFF_TCTRL     8'h00
`define TTC_OFF_TMODE     8'h01
`define TTC_OFF_U0_LO     8'h02
`define TTC_OFF_U1_LO     8'h03
`define TTC_OFF_U0_HI     8'h04
`define TTC_OFF_U1_HI     8'h05
`define TTC_OFF_T2CTRL    8'h06
`define TTC_OFF_T2MODE    8'h07
`define TTC_OFF_RCAP_LO   8'h08
`define TTC_OFF_RCAP_HI   8'h09
`define TTC_OFF_U2_LO     8'h0A
`define TTC_OFF_U2_HI     8'h0B
`define TTC_OFF_CFG       8'h0C

// timer_control_reg fields
`define TTC_TC_TF1        7
`define TTC_TC_TR1        6
`define TTC_TC_TF0        5
`define TTC_TC_TR0        4
// timer_mode_reg fields, per nibble
`define TTC_TM_GATE       3
`define TTC_TM_CT         2
// third_unit_control_reg fields
`define TTC_T2_TF2        7
`define TTC_T2_EXF2       6
`define TTC_T2_RCLK       5
`define TTC_T2_TCLK       4
`define TTC_T2_EXEN       3
`define TTC_T2_RUN        2
`define TTC_T2_CT         1
`define TTC_T2_CPRL       0
// third_unit_mode_reg and config fields
`define TTC_T2M_OE        1
`define TTC_CFG_SIX       0

`define TTC_RST_BYTE      8'h00
`define TTC_DIV_TWELVE    4'hC
`define TTC_DIV_SIX       4'h6

`endif

//--- ttc_pkg.sv
// types shared by the timer block
package ttc_pkg;
  typedef enum logic [1:0] {
    TTC_M13   = 2'h0,
    TTC_M16   = 2'h1,
    TTC_M8R   = 2'h2,
    TTC_SPLIT = 2'h3
  } ttc_mode_t;
endpackage

//--- ttc_div.sv
// machine-cycle and half-rate enable divider
`timescale 1ns/100ps
`include "ttc_defs.svh"
module ttc_div (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_six_clk,
  output logic      o_mc_en,
  output logic      o_half_en
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] last;

  // wrap at 12 or 6 oscillator clocks per machine cycle
  always_comb begin
    last    = (i_six_clk ? `TTC_DIV_SIX : `TTC_DIV_TWELVE) - 4'h1;
    cnt_nxt = (cnt_r >= last) ? 4'h0 : cnt_r + 4'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_mc_en   = (cnt_r == last);
  assign o_half_en = i_six_clk | cnt_r[0]; // every clock or every second clock
endmodule

//--- ttc_edge.sv
// pin sampler with falling-edge pulses
`timescale 1ns/100ps
module ttc_edge #(
  parameter int W = 6
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  // previous level, pins idle high
  always_comb begin
    prev_nxt = i_pins;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_r <= '1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign o_fall = prev_r & ~i_pins;
endmodule

//--- ttc_top.sv
// three 16-bit timer/counters with clock output on port 1 bit 0
//
// Notes on behaviour
// - three independent 16-bit units, each timer or event counter
// - each count readable and writable as high and low byte registers
// - mode register low nibble: modes 0..3, +4 counter, +8 pin gated, unit zero
// - high nibble configures unit one alike; mode 3 holds unit one
// - internal control: unit runs while its run bit is set
// - pin gated unit zero runs while run bit set and first irq pin high
// - pin gated unit one runs while run bit set and second irq pin high
// - third unit control: 00 reload, 01 capture, +2 counter, +8 pin enable
// - 34/24/14 select baud generation both, receive, transmit; +2 pin variants
// - without pin enable, reload only on overflow; capture mode never captures
// - pin enabled: falling capture pin edge also acts, except baud mode
// - 50% duty clock output on port 1 bit 0
// - port 1 bit 0 is also the third unit count input
// - clock out = osc / (n*(65536-reload)), n 2 six-clock, 4 twelve-clock
// - reload value is reload high and low bytes as one unsigned word
// - clock-out overflows raise no overflow flag, as in baud mode
// - baud generation and clock output may run together
// - output enable bit gates the clock onto port 1 bit 0
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "ttc_defs.svh"
module ttc_top
  import ttc_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [`TTC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic                   i_first_ext_irq_pin,
  input  wire logic                   i_second_ext_irq_pin,
  input  wire logic                   i_unit_zero_count_pin,
  input  wire logic                   i_unit_one_count_pin,
  input  wire logic                   i_p1_0,
  input  wire logic                   i_third_unit_capture_pin,
  output logic [7:0]                  o_rdata,
  output logic                        o_p1_0_out,
  output logic                        o_p1_0_oe,
  output logic                        o_rx_baud_tick,
  output logic                        o_tx_baud_tick,
  output logic                        o_unit_zero_ovf,
  output logic                        o_unit_one_ovf,
  output logic                        o_third_unit_ovf,
  output logic                        o_third_unit_ext
);
  // reset release through two flops
  logic rst_s1_r;
  logic rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b    <= rst_s1_r;
    end
  end

  // one step of a unit-zero/one style counter; returns {overflow, high, low}
  function automatic logic [16:0] ttc_step(input ttc_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [5:0]  l5;
    logic [8:0]  l9;
    logic [8:0]  h9;
    logic [16:0] r;
    l5 = {1'b0, lo[4:0]} + 6'h01;
    l9 = {1'b0, lo} + 9'h001;
    h9 = {1'b0, hi} + 9'h001;
    case (m)
      TTC_M13: begin // 5-bit prescale in low byte under the high byte
        if (l5[5]) r = {h9[8], h9[7:0], lo[7:5], 5'h00};
        else       r = {1'b0, hi, lo[7:5], l5[4:0]};
      end
      TTC_M16: begin
        if (l9[8]) r = {h9, 8'h00};
        else       r = {1'b0, hi, l9[7:0]};
      end
      TTC_M8R: begin // low byte reloads from high byte
        if (l9[8]) r = {1'b1, hi, hi};
        else       r = {1'b0, hi, l9[7:0]};
      end
      default: r = {l9[8], hi, l9[7:0]}; // split: low byte alone
    endcase
    return r;
  endfunction

  // rate enables and pin edges
  logic       mc_en;
  logic       half_en;
  logic [5:0] fall;
  logic       six_r;

  ttc_div u_div (
    .i_clk     (i_clk),
    .i_rst_b   (rst_b),
    .i_six_clk (six_r),
    .o_mc_en   (mc_en),
    .o_half_en (half_en)
  );

  ttc_edge #(.W(6)) u_edge (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_pins  ({i_third_unit_capture_pin, i_p1_0, i_unit_one_count_pin,
               i_unit_zero_count_pin, i_second_ext_irq_pin, i_first_ext_irq_pin}),
    .o_fall  (fall)
  );

  // register state
  logic [7:0] tmode_r;
  logic [7:0] tmode_nxt;
  logic       tr0_r;
  logic       tr0_nxt;
  logic       tr1_r;
  logic       tr1_nxt;
  logic       tf0_r;
  logic       tf0_nxt;
  logic       tf1_r;
  logic       tf1_nxt;
  logic [7:0] u0_lo_r;
  logic [7:0] u0_lo_nxt;
  logic [7:0] u0_hi_r;
  logic [7:0] u0_hi_nxt;
  logic [7:0] u1_lo_r;
  logic [7:0] u1_lo_nxt;
  logic [7:0] u1_hi_r;
  logic [7:0] u1_hi_nxt;
  logic [7:0] t2ctl_r;
  logic [7:0] t2ctl_nxt;
  logic       t2oe_r;
  logic       t2oe_nxt;
  logic       six_nxt;
  logic [7:0] rc_lo_r;
  logic [7:0] rc_lo_nxt;
  logic [7:0] rc_hi_r;
  logic [7:0] rc_hi_nxt;
  logic [7:0] u2_lo_r;
  logic [7:0] u2_lo_nxt;
  logic [7:0] u2_hi_r;
  logic [7:0] u2_hi_nxt;
  logic       clk_r;
  logic       clk_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       rx_r;
  logic       rx_nxt;
  logic       tx_r;
  logic       tx_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // decoded controls
  ttc_mode_t  m0, m1;
  logic       split0, run0, run1, run0h, tick0, tick1, tick0h;
  logic       baud, clkout, tick2, ovf2, ext2;
  logic [16:0] s0, s1, s0h;
  logic [16:0] c2;
  logic       wr_tc, wr_t2;

  always_comb begin
    m0     = ttc_mode_t'(tmode_r[1:0]);
    m1     = ttc_mode_t'(tmode_r[5:4]);
    split0 = (m0 == TTC_SPLIT);
    // gated units run while the irq pin is high
    run0   = tr0_r & (~tmode_r[`TTC_TM_GATE] | i_first_ext_irq_pin);
    run1   = tr1_r & (~tmode_r[`TTC_TM_GATE+4] | i_second_ext_irq_pin);
    tick0  = run0 & (tmode_r[`TTC_TM_CT] ? fall[2] : mc_en);
    tick1  = run1 & (tmode_r[`TTC_TM_CT+4] ? fall[3] : mc_en) & (m1 != TTC_SPLIT);
    run0h  = split0 & tr1_r; // split high byte borrows unit one run bit
    tick0h = run0h & mc_en;
    s0     = ttc_step(m0, u0_hi_r, u0_lo_r);
    s1     = ttc_step(m1, u1_hi_r, u1_lo_r);
    s0h    = ttc_step(TTC_SPLIT, 8'h00, u0_hi_r);
    // third unit
    baud   = t2ctl_r[`TTC_T2_RCLK] | t2ctl_r[`TTC_T2_TCLK];
    clkout = t2oe_r & ~t2ctl_r[`TTC_T2_CT];
    tick2  = t2ctl_r[`TTC_T2_RUN] & (t2ctl_r[`TTC_T2_CT] ? fall[4] :
             ((baud | clkout) ? half_en : mc_en));
    c2     = {1'b0, u2_hi_r, u2_lo_r} + 17'h0_0001;
    ovf2   = tick2 & c2[16];
    ext2   = t2ctl_r[`TTC_T2_EXEN] & fall[5] & ~baud;
    wr_tc  = i_wr & (i_addr == `TTC_OFF_TCTRL);
    wr_t2  = i_wr & (i_addr == `TTC_OFF_T2CTRL);
  end

  // unit zero and one next state
  always_comb begin
    tmode_nxt = (i_wr && i_addr == `TTC_OFF_TMODE) ? i_wdata : tmode_r;
    tr0_nxt   = wr_tc ? i_wdata[`TTC_TC_TR0] : tr0_r;
    tr1_nxt   = wr_tc ? i_wdata[`TTC_TC_TR1] : tr1_r;
    u0_lo_nxt = u0_lo_r;
    u0_hi_nxt = u0_hi_r;
    u1_lo_nxt = u1_lo_r;
    u1_hi_nxt = u1_hi_r;
    if (tick0) begin
      u0_lo_nxt = s0[7:0];
      if (!split0) u0_hi_nxt = s0[15:8];
    end
    if (tick0h) u0_hi_nxt = s0h[7:0];
    if (tick1) begin
      u1_lo_nxt = s1[7:0];
      u1_hi_nxt = s1[15:8];
    end
    // software writes win over counting in the same cycle
    if (i_wr && i_addr == `TTC_OFF_U0_LO) u0_lo_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_U0_HI) u0_hi_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_U1_LO) u1_lo_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_U1_HI) u1_hi_nxt = i_wdata;
    // overflow sets win over a software clear
    tf0_nxt = (wr_tc ? i_wdata[`TTC_TC_TF0] : tf0_r) | (tick0 & s0[16]);
    tf1_nxt = (wr_tc ? i_wdata[`TTC_TC_TF1] : tf1_r) |
              (split0 ? (tick0h & s0h[16]) : (tick1 & s1[16]));
  end

  // third unit next state
  always_comb begin
    t2ctl_nxt = wr_t2 ? i_wdata : t2ctl_r;
    t2oe_nxt  = (i_wr && i_addr == `TTC_OFF_T2MODE) ? i_wdata[`TTC_T2M_OE] : t2oe_r;
    six_nxt   = (i_wr && i_addr == `TTC_OFF_CFG) ? i_wdata[`TTC_CFG_SIX] : six_r;
    rc_lo_nxt = rc_lo_r;
    rc_hi_nxt = rc_hi_r;
    u2_lo_nxt = u2_lo_r;
    u2_hi_nxt = u2_hi_r;
    if (tick2) begin
      {u2_hi_nxt, u2_lo_nxt} = c2[15:0];
      if (ovf2) begin
        // reload from the capture pair unless in plain capture mode
        if (baud || clkout || !t2ctl_r[`TTC_T2_CPRL]) begin
          {u2_hi_nxt, u2_lo_nxt} = {rc_hi_r, rc_lo_r};
        end
      end
    end
    if (ext2) begin
      if (t2ctl_r[`TTC_T2_CPRL] && !clkout) begin // capture the running count
        {rc_hi_nxt, rc_lo_nxt} = {u2_hi_r, u2_lo_r};
      end else begin
        {u2_hi_nxt, u2_lo_nxt} = {rc_hi_r, rc_lo_r};
      end
    end
    if (i_wr && i_addr == `TTC_OFF_RCAP_LO) rc_lo_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_RCAP_HI) rc_hi_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_U2_LO) u2_lo_nxt = i_wdata;
    if (i_wr && i_addr == `TTC_OFF_U2_HI) u2_hi_nxt = i_wdata;
    // flags: hardware set wins; no overflow flag in baud or clock-out use
    t2ctl_nxt[`TTC_T2_TF2]  = t2ctl_nxt[`TTC_T2_TF2] |
                              (ovf2 & ~baud & ~clkout);
    t2ctl_nxt[`TTC_T2_EXF2] = t2ctl_nxt[`TTC_T2_EXF2] | ext2;
    // outputs: clock toggles per overflow, baud ticks share it
    clk_nxt = clkout ? (clk_r ^ ovf2) : 1'b0;
    oe_nxt  = clkout;
    rx_nxt  = ovf2 & t2ctl_r[`TTC_T2_RCLK];
    tx_nxt  = ovf2 & t2ctl_r[`TTC_T2_TCLK];
  end

  // read mux; data stand one cycle after the strobe only
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `TTC_OFF_TCTRL:   rdata_nxt = {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
        `TTC_OFF_TMODE:   rdata_nxt = tmode_r;
        `TTC_OFF_U0_LO:   rdata_nxt = u0_lo_r;
        `TTC_OFF_U1_LO:   rdata_nxt = u1_lo_r;
        `TTC_OFF_U0_HI:   rdata_nxt = u0_hi_r;
        `TTC_OFF_U1_HI:   rdata_nxt = u1_hi_r;
        `TTC_OFF_T2CTRL:  rdata_nxt = t2ctl_r;
        `TTC_OFF_T2MODE:  rdata_nxt = {6'h00, t2oe_r, 1'b0};
        `TTC_OFF_RCAP_LO: rdata_nxt = rc_lo_r;
        `TTC_OFF_RCAP_HI: rdata_nxt = rc_hi_r;
        `TTC_OFF_U2_LO:   rdata_nxt = u2_lo_r;
        `TTC_OFF_U2_HI:   rdata_nxt = u2_hi_r;
        `TTC_OFF_CFG:     rdata_nxt = {7'h00, six_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  // all state registers except the two reset release flops
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmode_r <= `TTC_RST_BYTE;
      tr0_r   <= 1'b0;
      tr1_r   <= 1'b0;
      tf0_r   <= 1'b0;
      tf1_r   <= 1'b0;
      u0_lo_r <= `TTC_RST_BYTE;
      u0_hi_r <= `TTC_RST_BYTE;
      u1_lo_r <= `TTC_RST_BYTE;
      u1_hi_r <= `TTC_RST_BYTE;
      t2ctl_r <= `TTC_RST_BYTE;
      t2oe_r  <= 1'b0;
      six_r   <= 1'b0;
      rc_lo_r <= `TTC_RST_BYTE;
      rc_hi_r <= `TTC_RST_BYTE;
      u2_lo_r <= `TTC_RST_BYTE;
      u2_hi_r <= `TTC_RST_BYTE;
      clk_r   <= 1'b0;
      oe_r    <= 1'b0;
      rx_r    <= 1'b0;
      tx_r    <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      tmode_r <= tmode_nxt;
      tr0_r   <= tr0_nxt;
      tr1_r   <= tr1_nxt;
      tf0_r   <= tf0_nxt;
      tf1_r   <= tf1_nxt;
      u0_lo_r <= u0_lo_nxt;
      u0_hi_r <= u0_hi_nxt;
      u1_lo_r <= u1_lo_nxt;
      u1_hi_r <= u1_hi_nxt;
      t2ctl_r <= t2ctl_nxt;
      t2oe_r  <= t2oe_nxt;
      six_r   <= six_nxt;
      rc_lo_r <= rc_lo_nxt;
      rc_hi_r <= rc_hi_nxt;
      u2_lo_r <= u2_lo_nxt;
      u2_hi_r <= u2_hi_nxt;
      clk_r   <= clk_nxt;
      oe_r    <= oe_nxt;
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // outputs straight from flops
  assign o_rdata          = rdata_r;
  assign o_p1_0_out       = clk_r;
  assign o_p1_0_oe        = oe_r;
  assign o_rx_baud_tick   = rx_r;
  assign o_tx_baud_tick   = tx_r;
  assign o_unit_zero_ovf  = tf0_r;
  assign o_unit_one_ovf   = tf1_r;
  assign o_third_unit_ovf = t2ctl_r[`TTC_T2_TF2];
  assign o_third_unit_ext = t2ctl_r[`TTC_T2_EXF2];
endmodule

//--- ttc_top_monitor.sv
// assertion checker watching the timer block ports
`timescale 1ns/100ps
module ttc_top_monitor (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_third_unit_capture_pin,
  input wire logic [7:0] o_rdata,
  input wire logic       o_p1_0_out,
  input wire logic       o_p1_0_oe,
  input wire logic       o_rx_baud_tick,
  input wire logic       o_tx_baud_tick,
  input wire logic       o_unit_zero_ovf,
  input wire logic       o_unit_one_ovf,
  input wire logic       o_third_unit_ovf,
  input wire logic       o_third_unit_ext
);
  // software accesses that may clear flags, enable the pin or miss the map
  logic wr_tc;
  logic wr_t2;
  logic wr_oe;
  logic rd_bad;
  assign wr_tc  = i_wr && i_addr == 8'h00;
  assign wr_t2  = i_wr && i_addr == 8'h06;
  assign wr_oe  = i_wr && (i_addr == 8'h06 || i_addr == 8'h07);
  assign rd_bad = i_rd && i_addr > 8'h0C;
  // cycles since the capture pin was last low, saturating
  logic [2:0] low_age_r;
  logic [2:0] low_age_nxt;
  always_comb begin
    low_age_nxt = low_age_r;
    if (!i_third_unit_capture_pin) low_age_nxt = 3'h0;
    else if (low_age_r != 3'h7) low_age_nxt = low_age_r + 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_age_r <= 3'h7;
    else low_age_r <= low_age_nxt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_bad_rd;
    rd_bad ##1 1'b1;
  endsequence
  property p_rd_gap; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  property p_rd_bad; s_bad_rd |-> o_rdata == 8'h00; endproperty
  property p_f0_clr; $fell(o_unit_zero_ovf) |-> $past(wr_tc); endproperty
  property p_f1_clr; $fell(o_unit_one_ovf) |-> $past(wr_tc); endproperty
  property p_f2_clr; $fell(o_third_unit_ovf) |-> $past(wr_t2); endproperty
  property p_ext_clr; $fell(o_third_unit_ext) |-> $past(wr_t2); endproperty
  property p_ext_set; $rose(o_third_unit_ext) |-> low_age_r < 3'h5; endproperty
  property p_oe_rise; $rose(o_p1_0_oe) |-> $past(wr_oe, 2); endproperty
  property p_out_oe; o_p1_0_out |-> o_p1_0_oe; endproperty
  property p_tick_flag;
    $rose(o_third_unit_ovf) |-> !(o_rx_baud_tick || o_tx_baud_tick);
  endproperty
  property p_clk_flag;
    $changed(o_p1_0_out) && o_p1_0_oe |-> !$rose(o_third_unit_ovf);
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("read data outside its slot");
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not zero");
  a_f0_clr: assert property (p_f0_clr)
    else $error("unit zero flag fell without write");
  a_f1_clr: assert property (p_f1_clr)
    else $error("unit one flag fell without write");
  a_f2_clr: assert property (p_f2_clr)
    else $error("third flag fell without write");
  a_ext_clr: assert property (p_ext_clr)
    else $error("capture flag fell without write");
  a_ext_set: assert property (p_ext_set)
    else $error("capture flag rose without pin edge");
  a_oe_rise: assert property (p_oe_rise)
    else $error("pin drive began without write");
  a_out_oe: assert property (p_out_oe)
    else $error("clock high while pin not driven");
  a_tick_flag: assert property (p_tick_flag)
    else $error("overflow flag in baud mode");
  a_clk_flag: assert property (p_clk_flag)
    else $error("overflow flag in clock-out mode");
endmodule

//--- ttc_pins.sv
// far-side pin model: pulled-up event and capture pins
`timescale 1ns/100ps
module ttc_pins (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_pulse,
  output logic      [3:0] o_pin
);
  // a request pulls its pin low for two samples, then the pull-up wins
  logic [3:0] low_r = 4'h0;
  always_ff @(posedge i_clk) begin
    low_r <= i_pulse;
  end
  assign o_pin = ~(i_pulse | low_r);
endmodule

//--- test_triple_timer_counter_clockout.sv
// self-checking bench for the triple timer block
`timescale 1ns/100ps
module test_triple_timer_counter_clockout;
  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       gate0 = 1'b1;
  logic       gate1 = 1'b1;
  logic [3:0] pulse = 4'h0;
  logic [3:0] pin;
  logic       p10;
  logic [7:0] rdata;
  logic       clk_out, clk_oe, rx, tx;
  logic       f0, f1, f2, fx;
  logic [7:0] exp_q [$];
  logic       rd_pend = 1'b0;
  int         n_fail = 0, total_checks = 0, cyc = 0, n_rx = 0, n_tx = 0;
  logic [7:0] codes [4] = '{8'h34, 8'h24, 8'h14, 8'h3C};
  logic [7:0] t2c [3] = '{8'h04, 8'h04, 8'h34};
  logic [15:0] rl [3] = '{16'hFFFE, 16'hFFFE, 16'hFFFC};
  always #4 i_clk = ~i_clk;
  // port 1 bit 0 is driven by the block when enabled, else by the pin model
  assign p10 = clk_oe ? clk_out : pin[2];
  ttc_top i_ttc_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_first_ext_irq_pin(gate0),
    .i_second_ext_irq_pin(gate1), .i_unit_zero_count_pin(pin[0]),
    .i_unit_one_count_pin(pin[1]), .i_p1_0(p10), .i_third_unit_capture_pin(pin[3]),
    .o_rdata(rdata), .o_p1_0_out(clk_out), .o_p1_0_oe(clk_oe), .o_rx_baud_tick(rx),
    .o_tx_baud_tick(tx), .o_unit_zero_ovf(f0), .o_unit_one_ovf(f1),
    .o_third_unit_ovf(f2), .o_third_unit_ext(fx));
  ttc_pins i_ttc_pins (.i_clk(i_clk), .i_pulse(pulse), .o_pin(pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read data stand in the cycle after the strobe; compare with oldest note
  always @(posedge i_clk) begin
    if (rd_pend) chk(rdata, exp_q.pop_front());
    rd_pend <= i_rd;
    if (rx) n_rx <= n_rx + 1;
    if (tx) n_tx <= n_tx + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n - 1) @(posedge i_clk);
  endtask
  // each request gives one falling edge on the chosen pin
  task automatic hit(input int k, n);
    repeat (n) begin
      pulse[k] <= 1'b1;
      @(posedge i_clk);
      pulse[k] <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  // time the clock output half periods at falling clock edges
  task automatic meas(input int h);
    int n;
    logic v;
    @(negedge i_clk);
    v = clk_out;
    for (int k = 0; k < 5; k++) begin
      n = 0;
      while (clk_out === v && n < 40) begin
        @(negedge i_clk);
        n++;
      end
      v = clk_out;
      if (k > 0) chk(16'(n), 16'(h));
    end
    chk(16'(clk_oe), 16'h1);
    @(posedge i_clk);
  endtask
  function automatic logic ok_n(input int d, input logic en);
    return en ? (d >= 7 && d <= 9) : d == 0;
  endfunction
  initial begin
    logic [7:0] v;
    int a0, a1;
    void'($urandom(22));
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int a = 0; a < 14; a++) rd(8'(a), 8'h00);
    rd(8'hFF, 8'h00);
    for (int a = 2; a < 12; a++) if (a < 6 || a > 7) begin
      v = 8'($urandom);
      wr(8'(a), v);
      rd(8'(a), v);
    end
    $display("test registers done");
    wr(8'h01, 8'h21);
    wr(8'h02, 8'hF0);
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hFF);
    wr(8'h03, 8'hFF);
    wr(8'h00, 8'h50);
    idle(160);
    rd(8'h00, 8'hD0);
    idle(60);
    rd(8'h00, 8'hF0);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h00); // second clear once both units have stopped
    wr(8'h02, 8'h55);
    idle(40);
    rd(8'h02, 8'h55);
    rd(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h1E);
    wr(8'h04, 8'hFF);
    wr(8'h00, 8'h10);
    idle(40);
    rd(8'h00, 8'h30);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h03);
    wr(8'h02, 8'hFF);
    wr(8'h04, 8'hFF);
    wr(8'h00, 8'h50);
    idle(40);
    rd(8'h00, 8'hF0);
    chk(16'({f1, f0}), 16'h3);
    wr(8'h00, 8'h00);
    $display("test timers done");
    wr(8'h01, 8'h3D);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h20);
    wr(8'h00, 8'h50);
    gate0 <= 1'b0;
    idle(4);
    hit(0, 2);
    gate0 <= 1'b1;
    idle(4);
    hit(0, 3);
    idle(60);
    rd(8'h02, 8'h03);
    rd(8'h03, 8'h20);
    wr(8'h01, 8'hD0);
    wr(8'h03, 8'h20);
    gate1 <= 1'b0;
    idle(4);
    hit(1, 1);
    gate1 <= 1'b1;
    idle(4);
    hit(1, 4);
    idle(2);
    rd(8'h03, 8'h24);
    $display("test counters done");
    wr(8'h06, 8'h00);
    wr(8'h0A, 8'h00);
    wr(8'h0B, 8'h00);
    wr(8'h06, 8'h0F);
    idle(2);
    hit(2, 5);
    hit(3, 1);
    idle(2);
    rd(8'h08, 8'h05);
    rd(8'h09, 8'h00);
    rd(8'h06, 8'h4F);
    chk(16'(fx), 16'h1);
    wr(8'h06, 8'h06);
    wr(8'h08, 8'hAA);
    idle(2);
    hit(3, 1);
    idle(2);
    rd(8'h0A, 8'h05);
    rd(8'h06, 8'h06);
    $display("test capture done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 8'hF0);
      wr(8'h09, 8'hFF);
      wr(8'h0A, 8'hF0);
      wr(8'h0B, 8'hFF);
      wr(8'h06, codes[i]);
      idle(1);
      a0 = n_rx;
      a1 = n_tx;
      hit(3, 2);
      idle(246);
      chk(16'(ok_n(n_rx - a0, codes[i][5])), 16'h1);
      chk(16'(ok_n(n_tx - a1, codes[i][4])), 16'h1);
      rd(8'h06, codes[i]);
      chk(16'({f2, fx}), 16'h0);
    end
    $display("test baud done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h06, 8'h00);
      wr(8'h0C, 8'(i == 1));
      wr(8'h08, rl[i][7:0]);
      wr(8'h09, rl[i][15:8]);
      wr(8'h0A, rl[i][7:0]);
      wr(8'h0B, rl[i][15:8]);
      wr(8'h07, 8'h02);
      wr(8'h06, t2c[i]);
      idle(1);
      meas((i == 1 ? 2 : 4) * (65536 - int'(rl[i])) / 2);
      rd(8'h06, t2c[i]);
    end
    wr(8'h07, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h06, 8'h04);
    idle(3);
    chk(16'(clk_oe), 16'h0);
    idle(100);
    rd(8'h06, 8'h84);
    chk(16'(f2), 16'h1);
    wr(8'h06, 8'h00);
    idle(3);
    $display("test clock output done");
    print_verdict();
  end
endmodule
bind ttc_top ttc_top_monitor i_ttc_top_monitor (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_third_unit_capture_pin(i_third_unit_capture_pin), .o_rdata(o_rdata),
  .o_p1_0_out(o_p1_0_out), .o_p1_0_oe(o_p1_0_oe), .o_rx_baud_tick(o_rx_baud_tick),
  .o_tx_baud_tick(o_tx_baud_tick), .o_unit_zero_ovf(o_unit_zero_ovf),
  .o_unit_one_ovf(o_unit_one_ovf), .o_third_unit_ovf(o_third_unit_ovf),
  .o_third_unit_ext(o_third_unit_ext));
